/* rtl/link_regs.v */
// Contract
// - Registers reachable only through debugger link instructions, never by the processor.
// - Physical settings at offsets 0x0-0x3, access-layer registers at 0x7-0xC.
// - Read-only four-bit implementation revision in bits 7:4 of status one.
// - Error signature bits 2:0 load on link error, clear on debugger read.
// - Signature 0 no error, 1 parity error, 2 frame stop error.
// - Signature 3 access-layer timeout, 4 start-bit clock recovery error.
// - Signature 7 line contention; codes 5 and 6 never produced.
// - Gap enable inserts two idle characters between sent bytes after the first.
// - Parity ignore bit suppresses parity checking and parity errors.
// - Unless disabled, missing access reply within 65536 cycles is a timeout.
// - Reply signature off bit suppresses all response signatures.
// - Guard select 0..6 gives 128 down to 2 cycles; reset gives 128.
// - Guard select 7 turns guard time off entirely.
// - Negative acknowledge off bit suppresses nack on reset during load/store.
// - Collision check runs during own transmission unless the off bit is set.
// - Interface off resets interface, drops clock hold, clears settings and keys.
// - Key status bits 5, 4, 3 show user row, programming, erase keys.
// - Writing 0x59 holds system reset, other values release; bit 0 reads it.
// - Clock select 1,2,3 gives 16, 8, 4 MHz; reset value 3.
`timescale 1ns/1ps
`default_nettype none
`include "link_regs_defs.vh"

module link_regs #(
   parameter TIMEOUT_CYCLES = `TIMEOUT_CYCLES,
   parameter GAP_CHARS      = `GAP_CHARS,
   parameter CHAR_BITS      = `CHAR_BITS
) (
   // Clock and reset.
   input  wire       mclk,
   input  wire       rst,
   // Register access from the link instruction decoder.
   input  wire       reg_wr,
   input  wire       reg_rd,
   input  wire [3:0] reg_addr,
   input  wire [7:0] reg_wdata,
   output reg  [7:0] reg_rdata,
   // Link frame events from the physical layer.
   input  wire       parity_bad,
   input  wire       stop_bad,
   input  wire       start_bad,
   input  wire       rx_bit,
   input  wire       tx_bit,
   input  wire       tx_active,
   input  wire       bit_tick,
   // Transmit sequencing from the physical layer.
   input  wire       rx_to_tx,
   input  wire       next_byte,
   output reg        tx_allowed,
   output reg        send_reply_sig,
   // Access-layer handshake.
   input  wire       access_wait,
   input  wire       access_resp,
   input  wire       load_store_busy,
   input  wire       sys_reset_seen,
   output reg        send_nack,
   // Key and system state from the access layer.
   input  wire       erase_key_set,
   input  wire       nvm_key_set,
   input  wire       user_row_key_set,
   input  wire       key_done,
   input  wire       sys_asleep_in,
   input  wire       locked_in,
   input  wire [2:0] mem_check_in,
   // System control outputs.
   output reg        sys_reset_request,
   output reg        sys_clock_hold,
   output reg        user_row_commit,
   output reg  [1:0] link_clock_sel,
   output reg        interface_reset
);

   reg  [7:0] ctrl_reg;
   reg  [7:0] ctrl_two_reg;
   reg  [2:0] error_signature;
   reg  [2:0] keys_reg;
   reg        sys_reset_seen_reg;
   reg  [16:0] timeout_reg;
   reg  [2:0] contention_sync;
   reg  [2:0] tx_bit_dly_reg;
   reg  [2:0] tx_active_dly_reg;
   reg        guard_start;
   reg  [7:0] guard_len;
   reg        gap_pending;
   wire       guard_busy;
   wire       guard_done;
   wire       parity_err;
   wire       timeout_err;
   wire       contention_err;
   reg  [2:0] err_next;

   // Guard length in bit times for a given select code.
   function [7:0] guard_cycles;
      input [2:0] sel;
      begin
         if (sel == `GUARD_OFF_CODE)
            guard_cycles = 8'h00;
         else
            guard_cycles = 8'h80 >> sel;
      end
   endfunction

   guard_timer #(
      .WIDTH(8)
   ) u_guard (
      .mclk    (mclk),
      .rst     (rst),
      .start   (guard_start),
      .length  (guard_len),
      .bit_tick(bit_tick),
      .busy    (guard_busy),
      .done    (guard_done)
   );

   // Error causes, each gated by its control bit.
   assign parity_err     = parity_bad && !ctrl_reg[`BIT_PARITY_IGNORE];
   assign timeout_err    = access_wait && !ctrl_reg[`BIT_TIMEOUT_OFF] &&
                           (timeout_reg == TIMEOUT_CYCLES[16:0] - 17'h00001);
   assign contention_err = tx_active && tx_active_dly_reg[2] && !ctrl_two_reg[`BIT_COLLISION_OFF] &&
                           (contention_sync[2] == contention_sync[1]) &&
                           (contention_sync[2] != tx_bit_dly_reg[2]);

   // Newest error code; contention outranks the others.
   always @* begin
      err_next = error_signature;
      if (contention_err)
         err_next = `ERR_CONTENTION;
      else if (start_bad)
         err_next = `ERR_CLOCK_RECOVERY;
      else if (timeout_err)
         err_next = `ERR_TIMEOUT;
      else if (stop_bad)
         err_next = `ERR_FRAME;
      else if (parity_err)
         err_next = `ERR_PARITY;
      else if (reg_rd && reg_addr == `OFF_ERROR_STATUS)
         err_next = `ERR_NONE;
   end

   // The line level passes three flip-flops; the sent level is delayed alike to match it.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         contention_sync   <= 3'h0;
         tx_bit_dly_reg    <= 3'h0;
         tx_active_dly_reg <= 3'h0;
      end else begin
         contention_sync   <= {contention_sync[1:0], rx_bit};
         tx_bit_dly_reg    <= {tx_bit_dly_reg[1:0], tx_bit};
         tx_active_dly_reg <= {tx_active_dly_reg[1:0], tx_active};
      end
   end

   // Settings, keys and error capture; interface off resets settings, keys, error and clock select and drops clock hold.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_reg          <= `RST_PHY_CONTROL;
         ctrl_two_reg      <= `RST_PHY_CONTROL_TWO;
         error_signature   <= `ERR_NONE;
         keys_reg          <= 3'h0;
         sys_reset_request <= 1'b0;
         sys_clock_hold    <= 1'b1;
         user_row_commit   <= 1'b0;
         link_clock_sel    <= `RST_CLOCK_SEL;
         interface_reset   <= 1'b0;
         sys_reset_seen_reg <= 1'b0;
      end else if (reg_wr && reg_addr == `OFF_PHY_CONTROL_TWO &&
                   reg_wdata[`BIT_INTERFACE_OFF]) begin
         ctrl_reg        <= `RST_PHY_CONTROL;
         ctrl_two_reg    <= `RST_PHY_CONTROL_TWO;
         error_signature <= `ERR_NONE;
         keys_reg        <= 3'h0;
         sys_clock_hold  <= 1'b0;
         user_row_commit <= 1'b0;
         link_clock_sel  <= `RST_CLOCK_SEL;
         interface_reset <= 1'b1;
      end else begin
         interface_reset <= 1'b0;
         user_row_commit <= 1'b0;
         error_signature <= err_next;
         // Keys set by the access layer, cleared on completion.
         if (key_done)
            keys_reg <= 3'h0;
         keys_reg[0] <= (keys_reg[0] && !key_done) || erase_key_set;
         keys_reg[1] <= (keys_reg[1] && !key_done) || nvm_key_set;
         keys_reg[2] <= (keys_reg[2] && !key_done) || user_row_key_set;
         // Reset seen flag clears on read, set wins.
         sys_reset_seen_reg <= sys_reset_seen || sys_reset_request ||
                               (sys_reset_seen_reg &&
                                !(reg_rd && reg_addr == `OFF_SYS_ACCESS_STAT));
         if (reg_wr) begin
            case (reg_addr)
               `OFF_PHY_CONTROL: begin
                  ctrl_reg <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
               end
               `OFF_PHY_CONTROL_TWO: begin
                  ctrl_two_reg <= {3'h0, reg_wdata[4:3], 3'h0};
               end
               `OFF_KEY_STATUS: begin
                  if (reg_wdata[`BIT_USER_ROW_KEY])
                     keys_reg[2] <= user_row_key_set;
               end
               `OFF_RESET_REQUEST: begin
                  sys_reset_request <= (reg_wdata == `RESET_SIGNATURE);
               end
               `OFF_CLOCK_CONTROL: begin
                  if (reg_wdata[1:0] != 2'h0)
                     link_clock_sel <= reg_wdata[1:0];
               end
               `OFF_SYS_ACCESS_CTRL: begin
                  sys_clock_hold  <= reg_wdata[0];
                  user_row_commit <= reg_wdata[1] && keys_reg[2];
               end
               default: begin
               end
            endcase
         end
      end
   end

   // Access-layer reply timer runs while a response is awaited.
   always @(posedge mclk or posedge rst) begin
      if (rst)
         timeout_reg <= 17'h00000;
      else if (!access_wait || access_resp || timeout_err)
         timeout_reg <= 17'h00000;
      else
         timeout_reg <= timeout_reg + 17'h00001;
   end

   // Guard before the first byte, two idle characters between later bytes when the gap is enabled.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         guard_start <= 1'b0;
         guard_len   <= 8'h00;
         gap_pending <= 1'b0;
         tx_allowed  <= 1'b0;
      end else begin
         guard_start <= 1'b0;
         if (rx_to_tx) begin
            guard_start <= 1'b1;
            guard_len   <= guard_cycles(ctrl_reg[2:0]);
            tx_allowed  <= 1'b0;
            gap_pending <= 1'b0;
         end else if (next_byte && ctrl_reg[`BIT_GAP_EN]) begin
            guard_start <= 1'b1;
            guard_len   <= GAP_CHARS[7:0] * CHAR_BITS[7:0];
            tx_allowed  <= 1'b0;
            gap_pending <= 1'b1;
         end else if (guard_done) begin
            tx_allowed  <= 1'b1;
            gap_pending <= 1'b0;
         end else if (guard_busy) begin
            tx_allowed  <= 1'b0;
         end
      end
   end

   // Reply signature and negative acknowledge enables.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         send_reply_sig <= 1'b1;
         send_nack      <= 1'b0;
      end else begin
         send_reply_sig <= !ctrl_reg[`BIT_REPLY_SIG_OFF];
         send_nack      <= sys_reset_seen && load_store_busy &&
                           !ctrl_two_reg[`BIT_NEG_ACK_OFF] &&
                           !ctrl_reg[`BIT_REPLY_SIG_OFF];
      end
   end

   // Read data is registered; only the link decoder reaches this port.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `OFF_REVISION_STATUS: reg_rdata <= {`IMPL_REVISION, 4'h0};
            `OFF_ERROR_STATUS:    reg_rdata <= {5'h00, error_signature};
            `OFF_PHY_CONTROL:     reg_rdata <= ctrl_reg;
            `OFF_PHY_CONTROL_TWO: reg_rdata <= ctrl_two_reg;
            `OFF_KEY_STATUS:      reg_rdata <= {2'h0, keys_reg[2], keys_reg[1],
                                                keys_reg[0], 3'h0};
            `OFF_RESET_REQUEST:   reg_rdata <= {7'h00, sys_reset_request};
            `OFF_CLOCK_CONTROL:   reg_rdata <= {6'h00, link_clock_sel};
            `OFF_SYS_ACCESS_CTRL: reg_rdata <= {6'h00, 1'b0, sys_clock_hold};
            `OFF_SYS_ACCESS_STAT: reg_rdata <= {2'h0, sys_reset_seen_reg,
                                                sys_asleep_in, keys_reg[1],
                                                keys_reg[2], 1'b0, locked_in};
            `OFF_MEM_CHECK_STAT:  reg_rdata <= {5'h00, mem_check_in};
            default:              reg_rdata <= 8'h00;
         endcase
      end
   end

endmodule

`default_nettype wire

/* pkg/link_regs_defs.vh */
`ifndef LINK_REGS_DEFS_VH
`define LINK_REGS_DEFS_VH

// Register offsets in the link register space.
`define OFF_REVISION_STATUS   4'h0
`define OFF_ERROR_STATUS      4'h1
`define OFF_PHY_CONTROL       4'h2
`define OFF_PHY_CONTROL_TWO   4'h3
`define OFF_KEY_STATUS        4'h7
`define OFF_RESET_REQUEST     4'h8
`define OFF_CLOCK_CONTROL     4'h9
`define OFF_SYS_ACCESS_CTRL   4'hA
`define OFF_SYS_ACCESS_STAT   4'hB
`define OFF_MEM_CHECK_STAT    4'hC
`define PHY_LAST_OFFSET       4'h3

// Field positions.
`define BIT_GAP_EN            7
`define BIT_PARITY_IGNORE     5
`define BIT_TIMEOUT_OFF       4
`define BIT_REPLY_SIG_OFF     3
`define BIT_NEG_ACK_OFF       4
`define BIT_COLLISION_OFF     3
`define BIT_INTERFACE_OFF     2
`define BIT_USER_ROW_KEY      5
`define BIT_NVM_KEY           4
`define BIT_ERASE_KEY         3

// Reset values.
`define RST_PHY_CONTROL       8'h00
`define RST_PHY_CONTROL_TWO   8'h00
`define RST_CLOCK_SEL         2'h3
`define RST_SYS_ACCESS_CTRL   2'h1
// Arbitrary neutral implementation revision.
`define IMPL_REVISION         4'h5

// Error signature codes.
`define ERR_NONE              3'h0
`define ERR_PARITY            3'h1
`define ERR_FRAME             3'h2
`define ERR_TIMEOUT           3'h3
`define ERR_CLOCK_RECOVERY    3'h4
`define ERR_CONTENTION        3'h7

// System reset signature.
`define RESET_SIGNATURE       8'h59

// Guard time select code that switches guard time off.
`define GUARD_OFF_CODE        3'h7

// Access-layer response limit in link clock cycles.
`define TIMEOUT_CYCLES        65536
// Idle characters between bytes when the gap is enabled.
`define GAP_CHARS             2
// Bits in one idle character.
`define CHAR_BITS             12

`endif

/* rtl/guard_timer.v */
`timescale 1ns/1ps
`default_nettype none

// Counts a guard or gap wait in bit times and pulses done when it ends.
module guard_timer #(
   parameter WIDTH = 8
) (
   // Clock and reset.
   input  wire             mclk,
   input  wire             rst,
   // Control.
   input  wire             start,
   input  wire [WIDTH-1:0] length,
   input  wire             bit_tick,
   // Status.
   output reg              busy,
   output reg              done
);

   reg [WIDTH-1:0] count_reg;

   // Load on start, count down on each bit tick, pulse done at zero.
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         count_reg <= {WIDTH{1'b0}};
         busy      <= 1'b0;
         done      <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            if (length == {WIDTH{1'b0}}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               busy      <= 1'b1;
               count_reg <= length;
            end
         end else if (busy && bit_tick) begin
            if (count_reg == {{(WIDTH-1){1'b0}}, 1'b1}) begin
               busy <= 1'b0;
               done <= 1'b1;
            end
            count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule

`default_nettype wire

/* sim/link_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// Far end of the one-wire link: the line level with its pull-up, and bit pacing.
module link_far_end #(
   parameter TICK = 4
) (
   // Clock and reset.
   input  wire logic mclk,
   input  wire logic rst,
   // Near-end transmit and a debugger jam request.
   input  wire logic tx_active,
   input  wire logic tx_bit,
   input  wire logic jam,
   // Line level and bit pacing.
   output logic      rx_bit,
   output logic      bit_tick
);
   logic [7:0] cnt_reg;
   // A jamming debugger pulls low; otherwise the near end or the pull-up sets the line.
   assign rx_bit = jam ? 1'b0 : (tx_active ? tx_bit : 1'b1);
   assign bit_tick = (cnt_reg == 8'(TICK - 1));
   // One tick every TICK cycles paces guard and gap counting.
   always @(posedge mclk or posedge rst) begin
      if (rst)
         cnt_reg <= 8'h00;
      else
         cnt_reg <= bit_tick ? 8'h00 : cnt_reg + 8'h01;
   end
endmodule
`default_nettype wire

/* sim/link_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
`include "link_regs_defs.vh"
// Watches the register port and the system control outputs.
module link_regs_sva (
   // Clock and reset.
   input wire logic       mclk,
   input wire logic       rst,
   // Register port.
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   // Error sources.
   input wire logic       parity_bad,
   input wire logic       stop_bad,
   input wire logic       start_bad,
   input wire logic       access_wait,
   input wire logic       tx_active,
   // System control.
   input wire logic       sys_reset_request,
   input wire logic       sys_clock_hold,
   input wire logic [1:0] link_clock_sel,
   input wire logic       interface_reset
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // High while no error source can load the signature.
   wire quiet = !parity_bad && !stop_bad && !start_bad && !access_wait && !tx_active;
   // Two quiet signature reads three cycles apart.
   sequence s_sig_read;
      reg_rd && !reg_wr && reg_addr == 4'h1 && quiet;
   endsequence
   sequence s_two_reads;
      s_sig_read ##1 quiet [*2] ##1 s_sig_read;
   endsequence
   sequence s_off_req;
      reg_wr && reg_addr == 4'h3 && reg_wdata[2];
   endsequence
   property p_sig_clear;
      s_two_reads |=> reg_rdata[2:0] == 3'h0;
   endproperty
   a_sig_clear: assert property (p_sig_clear) else $error("signature kept after read");
   property p_sig_codes;
      reg_rd && !reg_wr && reg_addr == 4'h1
         |=> reg_rdata[7:3] == 5'h00 && !(reg_rdata[2:0] inside {3'h5, 3'h6});
   endproperty
   a_sig_codes: assert property (p_sig_codes) else $error("bad signature code");
   property p_unmapped;
      reg_rd && !reg_wr && (reg_addr inside {[4'h4:4'h6], [4'hD:4'hF]}) |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_revision;
      reg_rd && !reg_wr && reg_addr == 4'h0 |=> reg_rdata[7:4] == `IMPL_REVISION;
   endproperty
   a_revision: assert property (p_revision) else $error("revision field wrong");
   property p_rst_req;
      reg_wr && reg_addr == 4'h8 |=> sys_reset_request == ($past(reg_wdata) == `RESET_SIGNATURE);
   endproperty
   a_rst_req: assert property (p_rst_req) else $error("reset request wrong");
   property p_rst_read;
      reg_rd && !reg_wr && reg_addr == 4'h8 |=> reg_rdata == {7'h00, $past(sys_reset_request)};
   endproperty
   a_rst_read: assert property (p_rst_read) else $error("reset request readback wrong");
   property p_clk_keep;
      reg_wr && reg_addr == 4'h9 && reg_wdata[1:0] == 2'h0 |=> $stable(link_clock_sel);
   endproperty
   a_clk_keep: assert property (p_clk_keep) else $error("reserved clock select taken");
   property p_clk_set;
      reg_wr && reg_addr == 4'h9 && reg_wdata[1:0] != 2'h0
         |=> link_clock_sel == $past(reg_wdata[1:0]);
   endproperty
   a_clk_set: assert property (p_clk_set) else $error("clock select not taken");
   property p_off_pulse;
      s_off_req |-> ##[1:3] interface_reset;
   endproperty
   a_off_pulse: assert property (p_off_pulse) else $error("no interface reset");
   property p_off_hold;
      s_off_req |-> ##[1:3] !sys_clock_hold;
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("clock hold not dropped");
endmodule
bind link_regs link_regs_sva chk (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .reg_rdata, .parity_bad, .stop_bad, .start_bad, .access_wait, .tx_active,
   .sys_reset_request, .sys_clock_hold, .link_clock_sel, .interface_reset);
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "link_regs_defs.vh"
module tb_top;
   logic        mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [7:0]  reg_wdata = 8'h00, reg_rdata;
   logic [9:0]  ev = 10'h000;
   logic        tx_active = 1'b0, tx_bit = 1'b0, jam = 1'b0, access_wait = 1'b0;
   logic        load_store_busy = 1'b0, rx_bit, bit_tick, tx_allowed, send_reply_sig, send_nack;
   logic        sys_reset_request, sys_clock_hold, user_row_commit, interface_reset;
   logic [1:0]  link_clock_sel;
   logic [2:0]  mem_check_in = 3'h4;
   int          errors = 0, checks = 0, n;
   // Free-running 200 MHz clock.
   always #2.5 mclk = ~mclk;
   link_regs #(.TIMEOUT_CYCLES(16)) uut (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .parity_bad(ev[0]), .stop_bad(ev[1]), .start_bad(ev[2]), .rx_bit, .tx_bit,
      .tx_active, .bit_tick, .rx_to_tx(ev[3]), .next_byte(ev[4]), .tx_allowed, .send_reply_sig,
      .access_wait, .access_resp(ev[8]), .load_store_busy, .sys_reset_seen(ev[9]), .send_nack,
      .erase_key_set(ev[5]), .nvm_key_set(ev[6]), .user_row_key_set(ev[7]), .key_done(1'b0),
      .sys_asleep_in(1'b0), .locked_in(1'b0), .mem_check_in, .sys_reset_request,
      .sys_clock_hold, .user_row_commit, .link_clock_sel, .interface_reset);
   link_far_end far (.mclk, .rst, .tx_active, .tx_bit, .jam, .rx_bit, .bit_tick);
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      #1 chk(what, exp, reg_rdata);
   endtask
   task automatic pulse(input int i);
      @(posedge mclk);
      ev[i] <= 1'b1;
      @(posedge mclk);
      ev[i] <= 1'b0;
   endtask
   task automatic drive(input logic a, input logic b, input logic j, input int k);
      @(posedge mclk);
      tx_active <= a;
      tx_bit <= b;
      jam <= j;
      repeat (k) @(posedge mclk);
   endtask
   // Counts cycles from a direction change or next byte until sending is allowed.
   task automatic wait_tx(input int lo, input int hi);
      n = 2;
      repeat (2) @(posedge mclk);
      #1;
      while (tx_allowed !== 1'b1 && n < 2000) begin
         @(posedge mclk);
         #1 n++;
      end
      chk("wait in range", 8'h01, {7'h00, n >= lo && n <= hi});
      if (n >= 2000)
         give_verdict();
   endtask
   task automatic nack_test(input logic [7:0] ctl, input logic exp);
      logic seen;
      seen = 1'b0;
      wr(4'h3, ctl);
      pulse(9);
      repeat (4) begin
         #1 seen = seen | (send_nack === 1'b1);
         @(posedge mclk);
      end
      chk("nack", {7'h00, exp}, {7'h00, seen});
   endtask
   // Main sequence; each group ends with a progress line.
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      chk("clock select", 8'h03, {6'h00, link_clock_sel});
      chk("reply sig", 8'h01, {7'h00, send_reply_sig});
      wr(4'h0, 8'hFF);
      rd(4'h0, {`IMPL_REVISION, 4'h0}, "revision");
      rd(4'h5, 8'h00, "unmapped");
      rd(4'hC, 8'h04, "mem check");
      $display("test reset done");
      for (int i = 0; i < 3; i++) begin
         pulse(i);
         rd(4'h1, 8'(i == 2 ? 4 : i + 1), "signature");
         rd(4'h1, 8'h00, "cleared");
      end
      @(posedge mclk) access_wait <= 1'b1;
      repeat (80) @(posedge mclk);
      access_wait <= 1'b0;
      rd(4'h1, 8'h03, "timeout");
      drive(1'b1, 1'b1, 1'b1, 8);
      drive(1'b0, 1'b0, 1'b0, 4);
      rd(4'h1, 8'h07, "contention");
      wr(4'h3, 8'h08);
      drive(1'b1, 1'b1, 1'b1, 8);
      drive(1'b0, 1'b0, 1'b0, 4);
      rd(4'h1, 8'h00, "collision off");
      wr(4'h2, 8'h20);
      rd(4'h2, 8'h20, "control");
      pulse(0);
      rd(4'h1, 8'h00, "parity ignored");
      wr(4'h2, 8'h10);
      @(posedge mclk) access_wait <= 1'b1;
      repeat (80) @(posedge mclk);
      access_wait <= 1'b0;
      rd(4'h1, 8'h00, "timeout off");
      wr(4'h2, 8'h08);
      @(posedge mclk);
      #1 chk("reply sig", 8'h00, {7'h00, send_reply_sig});
      $display("test errors done");
      for (int s = 0; s < 8; s++) begin
         wr(4'h2, 8'(s));
         pulse(3);
         wait_tx(s == 7 ? 2 : ((128 >> s) - 1) * 4, s == 7 ? 4 : (128 >> s) * 4 + 12);
      end
      wr(4'h2, 8'h87);
      pulse(4);
      wait_tx((`GAP_CHARS * `CHAR_BITS - 1) * 4, `GAP_CHARS * `CHAR_BITS * 4 + 12);
      $display("test timing done");
      @(posedge mclk) load_store_busy <= 1'b1;
      nack_test(8'h10, 1'b0);
      nack_test(8'h00, 1'b1);
      @(posedge mclk) load_store_busy <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         pulse(5 + k);
         rd(4'h7, 8'((16 << k) - 8), "keys");
      end
      wr(4'hA, 8'h03);
      #1 chk("row commit", 8'h01, {7'h00, user_row_commit});
      rd(4'hA, 8'h01, "clock hold set");
      wr(4'h7, 8'h20);
      rd(4'h7, 8'h18, "row key cleared");
      wr(4'h2, 8'h25);
      wr(4'h8, `RESET_SIGNATURE);
      #1 chk("reset line", 8'h01, {7'h00, sys_reset_request});
      rd(4'h8, 8'h01, "reset request");
      rd(4'h2, 8'h25, "control kept");
      wr(4'h8, 8'h00);
      rd(4'h8, 8'h00, "reset released");
      wr(4'h9, 8'h01);
      wr(4'h9, 8'h00);
      rd(4'h9, 8'h01, "clock select");
      $display("test system done");
      wr(4'h3, 8'h04);
      repeat (4) @(posedge mclk);
      rd(4'h2, 8'h00, "control after off");
      rd(4'h7, 8'h00, "keys after off");
      chk("clock hold", 8'h00, {7'h00, sys_clock_hold});
      $display("test disable done");
      give_verdict();
   end
endmodule
`default_nettype wire
